/* File: pkg/decoder_regs.svh */
/*
 * Opcode values, opcode patterns, field positions and reset values of the
 * arithmetic, logic and string instruction decoder.
 * Assumes it is included by bare name into each design file that needs it.
 */
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH

// ****************************************************************
// Field positions in the opcode and address-form bytes
// ****************************************************************
`define W_BIT 0
`define DV_BIT 1
`define MOD_MSB 7
`define MOD_LSB 6
`define SEL_MSB 5
`define SEL_LSB 3
`define RM_MSB 2
`define RM_LSB 0
`define BYTE_SIGN 7
// Opcode bits that tell the logic and test forms apart
`define LOGIC_TEST_BIT 7
`define LOGIC_AND_BIT 5
`define LOGIC_XOR_BIT 4
`define LOGIC_OR_BIT 3

// ****************************************************************
// Address-form codes
// ****************************************************************
`define MOD_NODISP 2'h0
`define MOD_DISP8 2'h1
`define MOD_DISP16 2'h2
`define MOD_REG 2'h3
`define RM_DIRECT 3'h6

// ****************************************************************
// Exact opcodes
// ****************************************************************
`define OPC_ADJ_DIFF_ASCII 8'h3f
`define OPC_ADJ_DIFF_DEC 8'h2f
`define OPC_ADJ_PROD 8'hd4
`define OPC_ADJ_DIVIDEND 8'hd5
`define OPC_ADJ_BASE 8'h0a
`define OPC_BYTE_WORD 8'h98
`define OPC_WORD_DWORD 8'h99
`define OPC_EXIT_NEAR 8'hc3
`define OPC_EXIT_NEAR_POP 8'hc2
`define OPC_EXIT_FAR 8'hcb

// ****************************************************************
// Opcode patterns, ? marks the width and direction bits
// ****************************************************************
`define PAT_MULDIV 8'b1111011?
`define PAT_SHIFT 8'b110100??
`define PAT_LOGIC_IMM 8'b1000000?
`define PAT_AND_RM 8'b001000??
`define PAT_OR_RM 8'b000010??
`define PAT_XOR_RM 8'b001100??
`define PAT_TEST_RM 8'b1000010?
`define PAT_AND_ACC 8'b0010010?
`define PAT_OR_ACC 8'b0000110?
`define PAT_XOR_ACC 8'b0011010?
`define PAT_TEST_ACC 8'b1010100?
`define PAT_STR_COPY 8'b1010010?
`define PAT_STR_CMP 8'b1010011?
`define PAT_STR_LOAD 8'b1010110?
`define PAT_STR_STORE 8'b1010101?

// ****************************************************************
// Middle-field selectors and immediate lengths
// ****************************************************************
`define SEL_TEST 3'h0
`define SEL_UPROD 3'h4
`define SEL_SPROD 3'h5
`define SEL_UQUOT 3'h6
`define SEL_SQUOT 3'h7
`define SEL_ROL 3'h0
`define SEL_ROR 3'h1
`define SEL_RCL 3'h2
`define SEL_RCR 3'h3
`define SEL_SHL 3'h4
`define SEL_SHR 3'h5
`define SEL_SAR 3'h7
`define SEL_AND 3'h4
`define SEL_OR 3'h5
`define SEL_XOR 3'h6
`define IMM_NONE 2'h0
`define IMM_BYTE 2'h1
`define IMM_WORD 2'h2
`define DISP_NONE 2'h0
`define DISP_BYTE 2'h1
`define DISP_WORD 2'h2
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

`endif

/* File: pkg/decoder_pkg.sv */
/*
 * Types shared by the decoder modules: operation classes, opcode groups
 * and decoder states.
 * Assumes nothing of its surroundings.
 */
package decoder_pkg;
	typedef enum logic [4:0] {
		UNKNOWN = 5'b00000, ASCII_ADJUST_DIFFERENCE = 5'b00001,
		DECIMAL_ADJUST_DIFFERENCE = 5'b00010, UNSIGNED_PRODUCT = 5'b00011,
		SIGNED_PRODUCT = 5'b00100, UNSIGNED_QUOTIENT = 5'b00101,
		SIGNED_QUOTIENT = 5'b00110, ASCII_ADJUST_PRODUCT = 5'b00111,
		ASCII_ADJUST_DIVIDEND = 5'b01000, BYTE_TO_WORD_EXTEND = 5'b01001,
		WORD_TO_DWORD_EXTEND = 5'b01010, ROTATE_LEFT = 5'b01011,
		ROTATE_RIGHT = 5'b01100, ROTATE_CARRY_LEFT = 5'b01101,
		ROTATE_CARRY_RIGHT = 5'b01110, LEFT_SHIFT = 5'b01111,
		LOGICAL_RIGHT_SHIFT = 5'b10000, ARITH_RIGHT_SHIFT = 5'b10001,
		BIT_AND = 5'b10010, BIT_OR = 5'b10011, BIT_XOR = 5'b10100,
		BIT_TEST = 5'b10101, STRING_COPY = 5'b10110, STRING_COMPARE = 5'b10111,
		STRING_LOAD = 5'b11000, STRING_STORE = 5'b11001,
		EXIT_NEAR = 5'b11010, EXIT_NEAR_POP = 5'b11011, EXIT_FAR = 5'b11100
	} op_class_t;

	typedef enum logic [1:0] {
		GRP_NONE = 2'b00, GRP_MULDIV = 2'b01, GRP_SHIFT = 2'b10, GRP_LOGIC = 2'b11
	} grp_t;

	typedef enum logic [2:0] {
		S_OPCODE = 3'b000, S_MODRM = 3'b001, S_DISP_LO = 3'b010, S_DISP_HI = 3'b011,
		S_IMM_LO = 3'b100, S_IMM_HI = 3'b101, S_SECOND = 3'b110, S_HOLD = 3'b111
	} dec_state_t;
endpackage

/* File: hw/opcode_classify.sv */
/*
 * First-byte classifier: maps an opcode byte to its operation class, group,
 * the bytes that follow it and its width, direction and accumulator flags.
 * Assumes the caller samples the outputs only while the byte is an opcode.
 */
`timescale 1ns/1ps
`include "decoder_regs.svh"

module opcode_classify
	import decoder_pkg::*;
(
	input wire logic [7:0] opcode,
	output op_class_t cls,
	output grp_t grp,
	output logic needs_modrm,
	output logic second_fixed,
	output logic [1:0] imm_len,
	output logic wide,
	output logic dir_bit,
	output logic acc_op
);
	// ****************************************************************
	// Opcode table
	// ****************************************************************
	// Defaults stand for an opcode outside the decoded subset
	always_comb begin
		logic wsize;
		wsize = opcode[`W_BIT];
		cls = UNKNOWN;
		grp = GRP_NONE;
		needs_modrm = 1'b0;
		second_fixed = 1'b0;
		imm_len = `IMM_NONE;
		wide = wsize;
		dir_bit = 1'b0;
		acc_op = 1'b0;
		unique casez (opcode)
			`OPC_ADJ_DIFF_ASCII: cls = ASCII_ADJUST_DIFFERENCE;
			`OPC_ADJ_DIFF_DEC: cls = DECIMAL_ADJUST_DIFFERENCE;
			`OPC_ADJ_PROD: begin
				cls = ASCII_ADJUST_PRODUCT;
				second_fixed = 1'b1;
			end
			`OPC_ADJ_DIVIDEND: begin
				cls = ASCII_ADJUST_DIVIDEND;
				second_fixed = 1'b1;
			end
			`OPC_BYTE_WORD: acc_op = 1'b1;
			`OPC_WORD_DWORD: acc_op = 1'b1;
			`OPC_EXIT_NEAR: cls = EXIT_NEAR;
			`OPC_EXIT_NEAR_POP: begin
				cls = EXIT_NEAR_POP;
				imm_len = `IMM_WORD;
			end
			`OPC_EXIT_FAR: cls = EXIT_FAR;
			`PAT_MULDIV: begin
				grp = GRP_MULDIV;
				needs_modrm = 1'b1;
				imm_len = wsize ? `IMM_WORD : `IMM_BYTE;
			end
			`PAT_SHIFT: begin
				grp = GRP_SHIFT;
				needs_modrm = 1'b1;
			end
			`PAT_LOGIC_IMM: begin
				grp = GRP_LOGIC;
				needs_modrm = 1'b1;
				imm_len = wsize ? `IMM_WORD : `IMM_BYTE;
			end
			`PAT_AND_RM, `PAT_OR_RM, `PAT_XOR_RM, `PAT_TEST_RM: begin
				// XOR also has bit 5 set, so the XOR bit must be tested before AND is chosen
				cls = opcode[`LOGIC_TEST_BIT] ? BIT_TEST :
					(opcode[`LOGIC_XOR_BIT] ? BIT_XOR : (opcode[`LOGIC_OR_BIT] ? BIT_OR : BIT_AND));
				needs_modrm = 1'b1;
				dir_bit = opcode[`LOGIC_TEST_BIT] ? 1'b0 : opcode[`DV_BIT];
			end
			`PAT_AND_ACC, `PAT_OR_ACC, `PAT_XOR_ACC, `PAT_TEST_ACC: begin
				cls = opcode[`LOGIC_TEST_BIT] ? BIT_TEST :
					(opcode[`LOGIC_XOR_BIT] ? BIT_XOR : (opcode[`LOGIC_AND_BIT] ? BIT_AND : BIT_OR));
				imm_len = wsize ? `IMM_WORD : `IMM_BYTE;
				acc_op = 1'b1;
				dir_bit = 1'b1;
			end
			`PAT_STR_COPY: cls = STRING_COPY;
			`PAT_STR_CMP: cls = STRING_COMPARE;
			`PAT_STR_LOAD: begin
				cls = STRING_LOAD;
				acc_op = 1'b1;
				dir_bit = 1'b1;
			end
			`PAT_STR_STORE: begin
				cls = STRING_STORE;
				acc_op = 1'b1;
			end
			default: cls = UNKNOWN;
		endcase
		// Extend opcodes carry no width bit; source width is fixed
		if (opcode == `OPC_BYTE_WORD) begin
			cls = BYTE_TO_WORD_EXTEND;
		end
		if (opcode == `OPC_WORD_DWORD) begin
			cls = WORD_TO_DWORD_EXTEND;
		end
	end
endmodule

/* File: hw/modrm_length.sv */
/*
 * Address-form helper: number of displacement bytes after the address-form
 * byte, and whether the operand field names a register.
 * Assumes mod and rm come straight from the address-form byte.
 */
`timescale 1ns/1ps
`include "decoder_regs.svh"

module modrm_length (
	input wire logic [1:0] mod_in,
	input wire logic [2:0] rm_in,
	output logic [1:0] disp_len,
	output logic rm_is_reg
);
	// ****************************************************************
	// Displacement length
	// ****************************************************************
	// Direct address form hides a word displacement under mod 00
	always_comb begin
		rm_is_reg = (mod_in == `MOD_REG);
		unique case (mod_in)
			`MOD_NODISP: disp_len = (rm_in == `RM_DIRECT) ? `DISP_WORD : `DISP_NONE;
			`MOD_DISP8: disp_len = `DISP_BYTE;
			`MOD_DISP16: disp_len = `DISP_WORD;
			`MOD_REG: disp_len = `DISP_NONE;
		endcase
	end
endmodule

/* File: hw/arith_logic_string_decoder.sv */
/*
 * Instruction decoder for adjusts, multiply/divide, sign extension, shifts,
 * bitwise logic and test, string primitives and subroutine exit.
 * Assumes opcode bytes arrive in program order from the instruction queue
 * with a valid/ready handshake, and that the execution unit acknowledges a
 * decoded instruction with ex_ready.
 */
`timescale 1ns/1ps
`include "decoder_regs.svh"

module arith_logic_string_decoder
	import decoder_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic q_valid,
	input wire logic [7:0] q_byte,
	output logic q_ready,
	input wire logic ex_ready,
	output logic dec_valid,
	output op_class_t op_class,
	output logic op_wide,
	output logic op_dir,
	output logic acc_op,
	output logic count_from_reg,
	output logic flags_only,
	output logic [1:0] mod_field,
	output logic [2:0] reg_field,
	output logic [2:0] rm_field,
	output logic rm_is_reg,
	output logic [15:0] disp_value,
	output logic [15:0] imm_value
);
	dec_state_t st_r, st_nxt;
	logic take;
	logic [7:0] opcode_r;
	grp_t grp_r;
	logic [1:0] imm_len_r, disp_len_r;
	op_class_t class_r;
	logic wide_r, dir_r, acc_r, count_r, flags_r, rm_reg_r;
	logic [1:0] mod_r;
	logic [2:0] sel_r, rm_r;
	logic [15:0] disp_r, imm_r;
	op_class_t c_cls, g_cls;
	grp_t c_grp;
	logic c_modrm, c_second, c_wide, c_dir, c_acc;
	logic [1:0] c_imm, m_disp, imm_after;
	logic m_reg;
	logic [2:0] sel_in;
	logic in_w;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Class picked by the middle field of a grouped opcode
	function automatic op_class_t group_class(input grp_t g, input logic [2:0] sel);
		op_class_t c;
		c = UNKNOWN;
		unique case (g)
			GRP_MULDIV: case (sel)
				`SEL_TEST: c = BIT_TEST;
				`SEL_UPROD: c = UNSIGNED_PRODUCT;
				`SEL_SPROD: c = SIGNED_PRODUCT;
				`SEL_UQUOT: c = UNSIGNED_QUOTIENT;
				`SEL_SQUOT: c = SIGNED_QUOTIENT;
				default: c = UNKNOWN;
			endcase
			GRP_SHIFT: case (sel)
				`SEL_ROL: c = ROTATE_LEFT;
				`SEL_ROR: c = ROTATE_RIGHT;
				`SEL_RCL: c = ROTATE_CARRY_LEFT;
				`SEL_RCR: c = ROTATE_CARRY_RIGHT;
				`SEL_SHL: c = LEFT_SHIFT;
				`SEL_SHR: c = LOGICAL_RIGHT_SHIFT;
				`SEL_SAR: c = ARITH_RIGHT_SHIFT;
				default: c = UNKNOWN;
			endcase
			GRP_LOGIC: case (sel)
				`SEL_AND: c = BIT_AND;
				`SEL_OR: c = BIT_OR;
				`SEL_XOR: c = BIT_XOR;
				default: c = UNKNOWN;
			endcase
			GRP_NONE: c = UNKNOWN;
		endcase
		return c;
	endfunction

	// Only the test form of the multiply group, and the logic group, carry data
	function automatic logic [1:0] imm_for(input grp_t g, input logic [2:0] sel,
		input logic [1:0] len);
		return (g == GRP_SHIFT || (g == GRP_MULDIV && sel != `SEL_TEST)) ? `IMM_NONE : len;
	endfunction

	opcode_classify u_classify (
		.opcode(q_byte),
		.cls(c_cls),
		.grp(c_grp),
		.needs_modrm(c_modrm),
		.second_fixed(c_second),
		.imm_len(c_imm),
		.wide(c_wide),
		.dir_bit(c_dir),
		.acc_op(c_acc)
	);

	modrm_length u_modrm (
		.mod_in(q_byte[`MOD_MSB:`MOD_LSB]),
		.rm_in(q_byte[`RM_MSB:`RM_LSB]),
		.disp_len(m_disp),
		.rm_is_reg(m_reg)
	);

	// Queue is held off while a decoded instruction waits
	assign q_ready = (st_r != S_HOLD);
	assign take = q_valid && q_ready;
	assign sel_in = q_byte[`SEL_MSB:`SEL_LSB];
	assign in_w = q_byte[`W_BIT];
	assign g_cls = group_class(grp_r, sel_in);
	assign imm_after = imm_for(grp_r, sel_in, imm_len_r);

	// ****************************************************************
	// Byte sequencer
	// ****************************************************************
	// walk every byte before presenting, except after an unknown group code
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			S_OPCODE: if (take) begin
				if (c_modrm) begin
					st_nxt = S_MODRM;
				end else if (c_second) begin
					st_nxt = S_SECOND;
				end else if (c_imm != `IMM_NONE) begin
					st_nxt = S_IMM_LO;
				end else begin
					st_nxt = S_HOLD;
				end
			end
			S_MODRM: if (take) begin
				// Unknown group code stops here; trailing bytes are not consumed
				if (grp_r != GRP_NONE && g_cls == UNKNOWN) begin
					st_nxt = S_HOLD;
				end else if (m_disp != `DISP_NONE) begin
					st_nxt = S_DISP_LO;
				end else if (imm_after != `IMM_NONE) begin
					st_nxt = S_IMM_LO;
				end else begin
					st_nxt = S_HOLD;
				end
			end
			S_DISP_LO: if (take) begin
				if (disp_len_r == `DISP_WORD) begin
					st_nxt = S_DISP_HI;
				end else begin
					st_nxt = (imm_len_r != `IMM_NONE) ? S_IMM_LO : S_HOLD;
				end
			end
			S_DISP_HI: if (take) begin
				st_nxt = (imm_len_r != `IMM_NONE) ? S_IMM_LO : S_HOLD;
			end
			S_IMM_LO: if (take) begin
				st_nxt = (imm_len_r == `IMM_WORD) ? S_IMM_HI : S_HOLD;
			end
			S_IMM_HI: if (take) begin
				st_nxt = S_HOLD;
			end
			S_SECOND: if (take) begin
				st_nxt = S_HOLD;
			end
			S_HOLD: if (ex_ready) begin
				st_nxt = S_OPCODE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= S_OPCODE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Opcode-level fields
	// ****************************************************************
	// width bit taken from the opcode
	always_ff @(posedge clk) begin
		if (rst) begin
			opcode_r <= `RST_BYTE;
			grp_r <= GRP_NONE;
			imm_len_r <= `IMM_NONE;
			wide_r <= 1'b0;
			dir_r <= 1'b0;
			acc_r <= 1'b0;
			count_r <= 1'b0;
		end else if (take && st_r == S_OPCODE) begin
			opcode_r <= q_byte;
			grp_r <= c_grp;
			imm_len_r <= c_imm;
			wide_r <= c_wide;
			dir_r <= c_dir;
			acc_r <= c_acc;
			count_r <= (c_grp == GRP_SHIFT) && q_byte[`DV_BIT];
		end else if (take && st_r == S_MODRM) begin
			imm_len_r <= imm_after;
		end
	end

	// ****************************************************************
	// Operation class
	// ****************************************************************
	// group field decode
	always_ff @(posedge clk) begin
		if (rst) begin
			class_r <= UNKNOWN;
			flags_r <= 1'b0;
		end else if (take && st_r == S_OPCODE) begin
			class_r <= c_cls;
			flags_r <= (c_cls == BIT_TEST);
		end else if (take && st_r == S_MODRM && grp_r != GRP_NONE) begin
			class_r <= g_cls;
			flags_r <= (g_cls == BIT_TEST);
		end else if (take && st_r == S_SECOND && q_byte != `OPC_ADJ_BASE) begin
			// second byte must be the base
			class_r <= UNKNOWN;
		end
	end

	// ****************************************************************
	// Address-form, displacement and immediate
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst || (take && st_r == S_OPCODE)) begin
			mod_r <= `MOD_NODISP;
			sel_r <= `SEL_TEST;
			rm_r <= `SEL_TEST;
			rm_reg_r <= 1'b0;
			disp_len_r <= `DISP_NONE;
		end else if (take && st_r == S_MODRM) begin
			mod_r <= q_byte[`MOD_MSB:`MOD_LSB];
			sel_r <= sel_in;
			rm_r <= q_byte[`RM_MSB:`RM_LSB];
			rm_reg_r <= m_reg;
			disp_len_r <= m_disp;
		end
	end

	// Short displacement is sign-extended; immediates are zero-extended
	always_ff @(posedge clk) begin
		if (rst || (take && st_r == S_OPCODE)) begin
			disp_r <= `RST_WORD;
			imm_r <= `RST_WORD;
		end else if (take) begin
			unique case (st_r)
				S_DISP_LO: disp_r <= {{8{q_byte[`BYTE_SIGN]}}, q_byte};
				S_DISP_HI: disp_r[15:8] <= q_byte;
				S_IMM_LO: imm_r <= {`RST_BYTE, q_byte};
				S_IMM_HI: imm_r[15:8] <= q_byte;
				default: imm_r <= imm_r;
			endcase
		end
	end

	assign dec_valid = (st_r == S_HOLD);
	assign op_class = class_r;
	assign op_wide = wide_r;
	assign op_dir = dir_r;
	assign acc_op = acc_r;
	assign count_from_reg = count_r;
	assign flags_only = flags_r;
	assign mod_field = mod_r;
	assign reg_field = sel_r;
	assign rm_field = rm_r;
	assign rm_is_reg = rm_reg_r;
	assign disp_value = disp_r;
	assign imm_value = imm_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_adj_diff_ascii: assert property (
		take && st_r == S_OPCODE && q_byte == `OPC_ADJ_DIFF_ASCII
		|=> dec_valid && op_class == ASCII_ADJUST_DIFFERENCE)
		else $error("ascii adjust after subtract not decoded");
	chk_adj_diff_dec: assert property (
		take && st_r == S_OPCODE && q_byte == `OPC_ADJ_DIFF_DEC
		|=> dec_valid && op_class == DECIMAL_ADJUST_DIFFERENCE)
		else $error("decimal adjust after subtract not decoded");
	chk_signed_product: assert property (
		take && st_r == S_MODRM && grp_r == GRP_MULDIV && sel_in == `SEL_SPROD
		|=> op_class == SIGNED_PRODUCT && op_wide == opcode_r[`W_BIT])
		else $error("signed multiply not decoded");
	chk_adj_prod_pair: assert property (
		take && st_r == S_SECOND && opcode_r == `OPC_ADJ_PROD && q_byte == `OPC_ADJ_BASE
		|=> dec_valid && op_class == ASCII_ADJUST_PRODUCT)
		else $error("ascii adjust after multiply not decoded");
	chk_adj_bad_base: assert property (
		take && st_r == S_SECOND && q_byte != `OPC_ADJ_BASE |=> op_class == UNKNOWN)
		else $error("bad adjust base byte accepted");
	chk_word_extend: assert property (
		take && st_r == S_OPCODE && q_byte == `OPC_WORD_DWORD
		|=> op_class == WORD_TO_DWORD_EXTEND && op_wide && acc_op)
		else $error("word to double word extend not decoded");
	chk_arith_shift: assert property (
		take && st_r == S_MODRM && grp_r == GRP_SHIFT && sel_in == `SEL_SAR
		|=> op_class == ARITH_RIGHT_SHIFT && dec_valid == ($past(m_disp) == `DISP_NONE))
		else $error("arithmetic right shift not decoded");
	chk_shift_count: assert property (
		dec_valid && grp_r == GRP_SHIFT |-> count_from_reg == opcode_r[`DV_BIT])
		else $error("shift count source wrong");
	chk_reg_no_disp: assert property (
		take && st_r == S_MODRM && q_byte[`MOD_MSB:`MOD_LSB] == `MOD_REG
		|=> st_r != S_DISP_LO && rm_is_reg)
		else $error("register form expected displacement");
	chk_exit_pop_imm: assert property (
		take && st_r == S_OPCODE && q_byte == `OPC_EXIT_NEAR_POP
		|=> st_r == S_IMM_LO && imm_len_r == `IMM_WORD)
		else $error("exit with pop did not expect a word");
	chk_test_flags: assert property (
		dec_valid && op_class == BIT_TEST |-> flags_only)
		else $error("test class without flags only");
	chk_load_acc: assert property (
		take && st_r == S_OPCODE && q_byte ==? `PAT_STR_LOAD
		|=> op_class == STRING_LOAD && acc_op && op_dir && op_wide == $past(in_w))
		else $error("string load not tied to the accumulator");
	chk_hold_stable: assert property (
		dec_valid && !ex_ready |=> dec_valid && $stable(op_class) && $stable(imm_value))
		else $error("decoded output changed while held");

	cov_exit_pop: cover property (take && st_r == S_OPCODE && q_byte == `OPC_EXIT_NEAR_POP
		##[1:8] dec_valid);
	cov_disp_word: cover property (st_r == S_DISP_HI ##1 st_r == S_IMM_LO);
	cov_muldiv: cover property (dec_valid && op_class == UNSIGNED_QUOTIENT);
	cov_stall: cover property (dec_valid && !ex_ready ##1 dec_valid);
endmodule

/* File: verif/queue_exec_model.sv */
/*
 * Model of the instruction queue and the execution unit beside the decoder.
 * Assumes a byte is taken at a rising edge with q_valid and q_ready high.
 */
`timescale 1ns/1ps

module queue_exec_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic q_ready,
	input wire logic stall,
	output logic q_valid,
	output logic [7:0] q_byte,
	output logic ex_ready
);
	logic [7:0] fifo[$];
	logic taken;

	// Bench pushes bytes in program order
	function automatic void push(input logic [7:0] b);
		fifo.push_back(b);
	endfunction

	initial begin
		q_valid = 1'b0;
		q_byte = 8'h5a;
		ex_ready = 1'b0;
	end

	// Empty queue shows a changing byte, never a stale one
	always @(posedge clk) begin
		taken = q_valid && q_ready && !rst;
		#1;
		if (taken) fifo.pop_front();
		q_valid = fifo.size() != 0;
		q_byte = q_valid ? fifo[0] : ~q_byte;
		ex_ready = !stall && !rst;
	end
endmodule

/* File: verif/arith_logic_string_decoder_tb.sv */
/*
 * Self-checking bench for the instruction decoder.
 * Assumes the queue and execution model drives the handshake side.
 */
`timescale 1ns/1ps

module arith_logic_string_decoder_tb;
	import decoder_pkg::*;
	logic clk = 1'b0, rst = 1'b1, stall = 1'b0;
	logic q_valid, q_ready, ex_ready, dec_valid, op_wide, op_dir, acc_op;
	logic count_from_reg, flags_only, rm_is_reg;
	logic [7:0] q_byte;
	logic [1:0] mod_field;
	logic [2:0] reg_field, rm_field;
	logic [15:0] disp_value, imm_value;
	op_class_t op_class;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	op_class_t md[4] = '{UNSIGNED_PRODUCT, SIGNED_PRODUCT, UNSIGNED_QUOTIENT, SIGNED_QUOTIENT};
	op_class_t sh[8] = '{ROTATE_LEFT, ROTATE_RIGHT, ROTATE_CARRY_LEFT, ROTATE_CARRY_RIGHT,
		LEFT_SHIFT, LOGICAL_RIGHT_SHIFT, UNKNOWN, ARITH_RIGHT_SHIFT};

	always #5 clk = ~clk;

	arith_logic_string_decoder dut (.clk(clk), .rst(rst), .q_valid(q_valid), .q_byte(q_byte),
		.q_ready(q_ready), .ex_ready(ex_ready), .dec_valid(dec_valid), .op_class(op_class),
		.op_wide(op_wide), .op_dir(op_dir), .acc_op(acc_op), .count_from_reg(count_from_reg),
		.flags_only(flags_only), .mod_field(mod_field), .reg_field(reg_field),
		.rm_field(rm_field), .rm_is_reg(rm_is_reg), .disp_value(disp_value),
		.imm_value(imm_value));
	queue_exec_model m (.clk(clk), .rst(rst), .q_ready(q_ready), .stall(stall),
		.q_valid(q_valid), .q_byte(q_byte), .ex_ready(ex_ready));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	// Push n bytes, low byte first, and check the decoded instruction
	task automatic dec(input logic [31:0] b, input int n, input op_class_t c,
			input logic [2:0] wda, input logic [15:0] imm, input logic cw = 1'b1);
		int k;
		k = 0;
		for (int i = 0; i < n; i++) m.push(b[8*i +: 8]);
		while (dec_valid === 1'b1 && k < 20) begin
			@(posedge clk);
			#2;
			k++;
		end
		do begin
			@(posedge clk);
			#2;
			k++;
		end while (dec_valid !== 1'b1 && k < 40);
		chk("op_class", {11'h0, c}, {11'h0, op_class});
		if (cw) chk("wide_dir_acc", {13'h0, wda}, {13'h0, op_wide, op_dir, acc_op});
		chk("imm_value", imm, imm_value);
	endtask

	task automatic t_adjust;
		dec(32'h3f, 1, ASCII_ADJUST_DIFFERENCE, 3'h0, 16'h0, 1'b0);
		dec(32'h2f, 1, DECIMAL_ADJUST_DIFFERENCE, 3'h0, 16'h0, 1'b0);
		dec(32'h0ad4, 2, ASCII_ADJUST_PRODUCT, 3'h0, 16'h0, 1'b0);
		dec(32'h0ad5, 2, ASCII_ADJUST_DIVIDEND, 3'h0, 16'h0, 1'b0);
		dec(32'h0bd5, 2, UNKNOWN, 3'h0, 16'h0, 1'b0);
		dec(32'h98, 1, BYTE_TO_WORD_EXTEND, 3'h1, 16'h0);
		dec(32'h99, 1, WORD_TO_DWORD_EXTEND, 3'h5, 16'h0);
		$display("adjust and extend done");
	endtask

	task automatic t_muldiv;
		for (int s = 4; s < 8; s++) begin
			dec({16'h0, 2'h3, s[2:0], 3'h2, 7'h7b, s[0]}, 2, md[s-4], {s[0], 2'h0}, 16'h0);
			chk("rm_is_reg", 16'h1, {15'h0, rm_is_reg});
			chk("reg_rm", {10'h0, s[2:0], 3'h2}, {10'h0, reg_field, rm_field});
		end
		dec(32'habcdc1f7, 4, BIT_TEST, 3'h4, 16'habcd);
		chk("flags_only", 16'h1, {15'h0, flags_only});
		$display("multiply and divide done");
	endtask

	task automatic t_shift;
		for (int s = 0; s < 8; s++) begin
			if (s == 6) continue;
			dec({16'h0, 2'h3, s[2:0], 3'h1, 6'h34, s[0], s[1]}, 2, sh[s], {s[1], 2'h0},
				16'h0);
			chk("count_from_reg", {15'h0, s[0]}, {15'h0, count_from_reg});
		end
		$display("shift and rotate done");
	endtask

	task automatic t_logic;
		dec(32'hc322, 2, BIT_AND, 3'h2, 16'h0);
		dec(32'h5ae180, 3, BIT_AND, 3'h0, 16'h005a);
		dec(32'h123425, 3, BIT_AND, 3'h7, 16'h1234);
		dec(32'habcde981, 4, BIT_OR, 3'h4, 16'habcd);
		dec(32'h11f180, 3, BIT_XOR, 3'h0, 16'h0011);
		dec(32'h7f0c, 2, BIT_OR, 3'h3, 16'h007f);
		dec(32'habcd35, 3, BIT_XOR, 3'h7, 16'habcd);
		dec(32'h5aa8, 2, BIT_TEST, 3'h3, 16'h005a);
		dec(32'hf04685, 3, BIT_TEST, 3'h4, 16'h0);
		chk("disp_value", 16'hfff0, disp_value);
		chk("rm_is_reg", 16'h0, {15'h0, rm_is_reg});
		chk("mod_field", 16'h1, {14'h0, mod_field});
		chk("flags_only", 16'h1, {15'h0, flags_only});
		$display("logic and test done");
	endtask

	task automatic t_string;
		dec(32'ha4, 1, STRING_COPY, 3'h0, 16'h0);
		dec(32'ha7, 1, STRING_COMPARE, 3'h4, 16'h0);
		dec(32'hac, 1, STRING_LOAD, 3'h3, 16'h0);
		dec(32'had, 1, STRING_LOAD, 3'h7, 16'h0);
		dec(32'haa, 1, STRING_STORE, 3'h1, 16'h0);
		dec(32'hab, 1, STRING_STORE, 3'h5, 16'h0);
		$display("string primitives done");
	endtask

	task automatic t_exit;
		dec(32'hc3, 1, EXIT_NEAR, 3'h0, 16'h0, 1'b0);
		dec(32'hcb, 1, EXIT_FAR, 3'h0, 16'h0, 1'b0);
		dec(32'h1234c2, 3, EXIT_NEAR_POP, 3'h0, 16'h1234);
		$display("subroutine exit done");
	endtask

	// A stalled execution unit must freeze the decoder and its queue
	task automatic t_stall;
		stall = 1'b1;
		dec(32'h3f, 1, ASCII_ADJUST_DIFFERENCE, 3'h0, 16'h0, 1'b0);
		m.push(8'h2f);
		repeat (3) begin
			@(posedge clk);
			#2;
			chk("held", 16'h0002, {14'h0, dec_valid, q_ready});
			chk("held_class", {11'h0, ASCII_ADJUST_DIFFERENCE}, {11'h0, op_class});
		end
		stall = 1'b0;
		dec(32'h0, 0, DECIMAL_ADJUST_DIFFERENCE, 3'h0, 16'h0, 1'b0);
		$display("stall done");
	endtask

	// Reset in mid-instruction must drop the half-decoded opcode
	task automatic t_reset;
		m.push(8'hd4);
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b1;
		@(posedge clk);
		#2;
		chk("reset_hs", 16'h0001, {14'h0, dec_valid, q_ready});
		chk("reset_class", {11'h0, UNKNOWN}, {11'h0, op_class});
		chk("reset_imm", 16'h0, imm_value);
		@(posedge clk);
		#1;
		rst = 1'b0;
		dec(32'h3f, 1, ASCII_ADJUST_DIFFERENCE, 3'h0, 16'h0, 1'b0);
		$display("mid-run reset done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Cut a hang short well beyond the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		t_adjust();
		t_muldiv();
		t_shift();
		t_logic();
		t_string();
		t_exit();
		t_stall();
		t_reset();
		test_done();
	end
endmodule
